// File: berl_pkg.sv
// Constants for the system bus error log and report block
package berl_pkg;

  // ==========================================================================
  // Data and address widths
  // ==========================================================================
  localparam int unsigned BERL_LOG_W = 8;
  localparam int unsigned BERL_APB_AW = 12;
  localparam int unsigned BERL_APB_DW = 32;
  localparam int unsigned BERL_BUS_AW = 36;

  // ==========================================================================
  // Register indices as printed, byte address is four times the index
  // ==========================================================================
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_HL_SERR_EN = 12'h05c;
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_SB_FIRST = 12'h060;
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_SB_NEXT = 12'h062;
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_SB_SCI_EN = 12'h068;
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_SB_SMI_EN = 12'h06a;
  localparam logic [BERL_APB_AW-1:0] BERL_IDX_SB_SERR_EN = 12'h06c;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_HL_SERR_EN = BERL_IDX_HL_SERR_EN << 2;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_SB_FIRST = BERL_IDX_SB_FIRST << 2;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_SB_NEXT = BERL_IDX_SB_NEXT << 2;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_SB_SCI_EN = BERL_IDX_SB_SCI_EN << 2;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_SB_SMI_EN = BERL_IDX_SB_SMI_EN << 2;
  localparam logic [BERL_APB_AW-1:0] BERL_ADR_SB_SERR_EN = BERL_IDX_SB_SERR_EN << 2;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [BERL_LOG_W-1:0] BERL_RST_ENABLE = 8'h00;
  localparam logic [BERL_LOG_W-1:0] BERL_RST_LOG = 8'h00;

  // ==========================================================================
  // Field positions, shared by both system bus logs and their enables
  // ==========================================================================
  localparam int unsigned BERL_SB_BUS_INIT = 7;
  localparam int unsigned BERL_SB_PROC_ERR = 6;
  localparam int unsigned BERL_SB_NON_DRAM_LOCK = 5;
  localparam int unsigned BERL_SB_ABOVE_TOP = 4;
  localparam int unsigned BERL_SB_DATA_PAR = 3;
  localparam int unsigned BERL_SB_ADDR_GLITCH = 2;
  localparam int unsigned BERL_SB_DATA_GLITCH = 1;
  localparam int unsigned BERL_SB_REQ_PAR = 0;

  // Hub link log fields and the writable mask of its enable register
  localparam int unsigned BERL_HL_TARGET_ABORT = 6;
  localparam int unsigned BERL_HL_DATA_PAR = 4;
  localparam int unsigned BERL_HL_ADDR_CMD_PAR = 0;
  localparam logic [BERL_LOG_W-1:0] BERL_HL_EN_MASK = 8'h51;

  // Addresses at or above this value lie above 4 GB
  localparam logic [BERL_BUS_AW-1:0] BERL_FOUR_GB = 36'h1_0000_0000;

  // Synchroniser depth for pins
  localparam int unsigned BERL_SYNC_STAGES = 2;

endpackage

// File: berl_err_log.sv
// Sticky first and next error log pair with write-one-to-clear
`timescale 1ns/10ps
`default_nettype none

module berl_err_log
  import berl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic pwr_rst_b_i,
  input wire logic ce_i,
  input wire logic [BERL_LOG_W-1:0] event_i,
  input wire logic [BERL_LOG_W-1:0] clr_first_i,
  input wire logic [BERL_LOG_W-1:0] clr_next_i,
  output logic [BERL_LOG_W-1:0] first_o,
  output logic [BERL_LOG_W-1:0] next_o
);

  typedef struct packed {
    logic [BERL_LOG_W-1:0] first;
    logic [BERL_LOG_W-1:0] next;
  } berl_log_s;

  berl_log_s log_ff;
  berl_log_s nxt_log;

  // ==========================================================================
  // Log update
  // ==========================================================================
  // Occupancy is judged on the held value, so a clear and a fresh event in
  // one cycle still keeps the event: it lands in the next log
  always_comb
  begin
    nxt_log = log_ff;
    nxt_log.first = log_ff.first & ~clr_first_i;
    nxt_log.next = log_ff.next & ~clr_next_i;
    if (log_ff.first == BERL_RST_LOG)
    begin
      nxt_log.first = nxt_log.first | event_i;
    end
    else
    begin
      nxt_log.next = nxt_log.next | event_i;
    end
  end

  // Only the power-up reset clears the logs, a warm reset leaves them
  always_ff @(posedge sys_clk_i or negedge pwr_rst_b_i)
  begin
    if (!pwr_rst_b_i)
    begin
      log_ff <= '{first: BERL_RST_LOG, next: BERL_RST_LOG};
    end
    else if (ce_i)
    begin
      log_ff <= nxt_log;
    end
  end

  assign first_o = log_ff.first;
  assign next_o = log_ff.next;

endmodule

`default_nettype wire

// File: berl_top.sv
// Error capture and report block for the system bus with APB registers
`timescale 1ns/10ps
`default_nettype none

module berl_top
  import berl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic pwr_rst_b_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [BERL_APB_AW-1:0] paddr_i,
  input wire logic [BERL_APB_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [BERL_APB_DW-1:0] prdata_o,
  // Processor error pins, active low, asynchronous
  input wire logic bus_init_pin_b_i,
  input wire logic internal_error_pin_b_i,
  input wire logic machine_check_error_pin_b_i,
  // Error strobes from bus logic on this clock
  input wire logic locked_io_cycle_i,
  input wire logic lock_maps_dram_i,
  input wire logic bus_addr_valid_i,
  input wire logic [BERL_BUS_AW-1:0] bus_addr_i,
  input wire logic [BERL_BUS_AW-1:0] top_of_memory_i,
  input wire logic bus_data_parity_error_i,
  input wire logic address_strobe_glitch_i,
  input wire logic data_strobe_glitch_i,
  input wire logic request_address_parity_error_i,
  // Hub link error logs, held by the hub link block
  input wire logic [BERL_LOG_W-1:0] hub_link_first_error_log_i,
  input wire logic [BERL_LOG_W-1:0] hub_link_next_error_log_i,
  // Message requests
  output logic serr_o,
  output logic smi_o,
  output logic sci_o
);

  // ==========================================================================
  // Reset synchronisers
  // ==========================================================================
  // Both resets assert at once and release on the clock, two stages each
  logic [1:0] rst_sync_ff;
  logic [1:0] pwr_sync_ff;
  logic rst_b;
  logic pwr_rst_b;

  // Warm reset release, also held while the power-up reset is low
  always_ff @(posedge sys_clk_i or negedge rst_b_i or negedge pwr_rst_b_i)
  begin
    if (!rst_b_i || !pwr_rst_b_i)
    begin
      rst_sync_ff <= 2'h0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // Power-up reset release, it also forces the warm reset domain
  always_ff @(posedge sys_clk_i or negedge pwr_rst_b_i)
  begin
    if (!pwr_rst_b_i)
    begin
      pwr_sync_ff <= 2'h0;
    end
    else
    begin
      pwr_sync_ff <= {pwr_sync_ff[0], 1'b1};
    end
  end

  assign rst_b = rst_sync_ff[1];
  assign pwr_rst_b = pwr_sync_ff[1];

  // ==========================================================================
  // State of the block
  // ==========================================================================
  typedef struct packed {
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [2:0] pin_prev;
    logic [BERL_LOG_W-1:0] hl_serr_en;
    logic [BERL_LOG_W-1:0] sb_serr_en;
    logic [BERL_LOG_W-1:0] sb_smi_en;
    logic [BERL_LOG_W-1:0] sb_sci_en;
    logic [BERL_APB_DW-1:0] rdata;
    logic serr;
    logic smi;
    logic sci;
  } berl_top_s;

  berl_top_s st_ff;
  berl_top_s nxt_st;

  // ==========================================================================
  // Register decode
  // ==========================================================================
  logic sel_hl_en;
  logic sel_first;
  logic sel_next;
  logic sel_sci;
  logic sel_smi;
  logic sel_serr;
  logic mapped;

  // One select per register; anything else is answered with an error
  always_comb
  begin
    sel_hl_en = 1'b0;
    sel_first = 1'b0;
    sel_next = 1'b0;
    sel_sci = 1'b0;
    sel_smi = 1'b0;
    sel_serr = 1'b0;
    if (paddr_i == BERL_ADR_HL_SERR_EN)
    begin
      sel_hl_en = 1'b1;
    end
    else if (paddr_i == BERL_ADR_SB_FIRST)
    begin
      sel_first = 1'b1;
    end
    else if (paddr_i == BERL_ADR_SB_NEXT)
    begin
      sel_next = 1'b1;
    end
    else if (paddr_i == BERL_ADR_SB_SCI_EN)
    begin
      sel_sci = 1'b1;
    end
    else if (paddr_i == BERL_ADR_SB_SMI_EN)
    begin
      sel_smi = 1'b1;
    end
    else if (paddr_i == BERL_ADR_SB_SERR_EN)
    begin
      sel_serr = 1'b1;
    end
  end

  assign mapped = sel_hl_en | sel_first | sel_next | sel_sci | sel_smi | sel_serr;

  // Zero wait states; while the block is frozen the access simply waits
  assign pready_o = ce_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = st_ff.rdata;

  // Writes take effect at the access edge, only byte lane 0 carries data
  logic wr_en;
  logic [BERL_LOG_W-1:0] wr_byte;
  logic [BERL_LOG_W-1:0] clr_first;
  logic [BERL_LOG_W-1:0] clr_next;

  assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign wr_byte = pwdata_i[BERL_LOG_W-1:0];
  assign clr_first = (wr_en & sel_first) ? wr_byte : BERL_RST_LOG;
  assign clr_next = (wr_en & sel_next) ? wr_byte : BERL_RST_LOG;

  // ==========================================================================
  // Error event sources
  // ==========================================================================
  logic [2:0] pin_fall;
  logic [BERL_LOG_W-1:0] sb_event;
  logic above_top;

  // A falling pin is the logical assertion of an active-low error line
  assign pin_fall = st_ff.pin_prev & ~st_ff.pin_sync;

  // Compare against the top of memory and the 4 GB line
  assign above_top = bus_addr_valid_i & (bus_addr_i > top_of_memory_i)
                     & (bus_addr_i >= BERL_FOUR_GB);

  // Gather the eight system bus error sources into their log positions
  always_comb
  begin
    sb_event = BERL_RST_LOG;
    sb_event[BERL_SB_BUS_INIT] = pin_fall[0];
    sb_event[BERL_SB_PROC_ERR] = pin_fall[1] | pin_fall[2];
    sb_event[BERL_SB_NON_DRAM_LOCK] = locked_io_cycle_i & ~lock_maps_dram_i;
    sb_event[BERL_SB_ABOVE_TOP] = above_top;
    sb_event[BERL_SB_DATA_PAR] = bus_data_parity_error_i;
    sb_event[BERL_SB_ADDR_GLITCH] = address_strobe_glitch_i;
    sb_event[BERL_SB_DATA_GLITCH] = data_strobe_glitch_i;
    sb_event[BERL_SB_REQ_PAR] = request_address_parity_error_i;
  end

  // ==========================================================================
  // Sticky system bus logs
  // ==========================================================================
  logic [BERL_LOG_W-1:0] sb_first;
  logic [BERL_LOG_W-1:0] sb_next;

  // Kept in the power-up domain so a warm reset does not lose evidence
  berl_err_log u_sb_log (
    .sys_clk_i(sys_clk_i),
    .pwr_rst_b_i(pwr_rst_b),
    .ce_i(ce_i),
    .event_i(sb_event),
    .clr_first_i(clr_first),
    .clr_next_i(clr_next),
    .first_o(sb_first),
    .next_o(sb_next)
  );

  // ==========================================================================
  // Message generation
  // ==========================================================================
  logic [BERL_LOG_W-1:0] hl_flags;
  logic [BERL_LOG_W-1:0] sb_flags;
  logic hl_serr;

  // A flag in either log counts; only fields the hub link defines
  assign hl_flags = (hub_link_first_error_log_i | hub_link_next_error_log_i)
                    & BERL_HL_EN_MASK;
  assign sb_flags = sb_first | sb_next;

  // Each hub link enable gates exactly its own field
  assign hl_serr = (st_ff.hl_serr_en[BERL_HL_TARGET_ABORT] & hl_flags[BERL_HL_TARGET_ABORT])
                 | (st_ff.hl_serr_en[BERL_HL_DATA_PAR] & hl_flags[BERL_HL_DATA_PAR])
                 | (st_ff.hl_serr_en[BERL_HL_ADDR_CMD_PAR] & hl_flags[BERL_HL_ADDR_CMD_PAR]);

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Read data is latched in the setup cycle so it stands in the access phase
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pin_meta = {machine_check_error_pin_b_i, internal_error_pin_b_i,
                       bus_init_pin_b_i};
    nxt_st.pin_sync = st_ff.pin_meta;
    nxt_st.pin_prev = st_ff.pin_sync;
    if (wr_en & sel_hl_en)
    begin
      nxt_st.hl_serr_en = wr_byte & BERL_HL_EN_MASK;
    end
    if (wr_en & sel_sci)
    begin
      nxt_st.sb_sci_en = wr_byte;
    end
    if (wr_en & sel_smi)
    begin
      nxt_st.sb_smi_en = wr_byte;
    end
    if (wr_en & sel_serr)
    begin
      nxt_st.sb_serr_en = wr_byte;
    end
    if (psel_i & ~penable_i)
    begin
      nxt_st.rdata = '0;
      if (sel_hl_en)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = st_ff.hl_serr_en;
      end
      else if (sel_first)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = sb_first;
      end
      else if (sel_next)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = sb_next;
      end
      else if (sel_sci)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = st_ff.sb_sci_en;
      end
      else if (sel_smi)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = st_ff.sb_smi_en;
      end
      else if (sel_serr)
      begin
        nxt_st.rdata[BERL_LOG_W-1:0] = st_ff.sb_serr_en;
      end
    end
    // Levels follow flag and enable; no latch, so clearing drops them
    nxt_st.serr = hl_serr | (|(st_ff.sb_serr_en & sb_flags));
    nxt_st.smi = |(st_ff.sb_smi_en & sb_flags);
    nxt_st.sci = |(st_ff.sb_sci_en & sb_flags);
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Pins reset to their idle high level so release makes no false edge
  always_ff @(posedge sys_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '{pin_meta: 3'h7, pin_sync: 3'h7, pin_prev: 3'h7,
                 hl_serr_en: BERL_RST_ENABLE, sb_serr_en: BERL_RST_ENABLE,
                 sb_smi_en: BERL_RST_ENABLE, sb_sci_en: BERL_RST_ENABLE,
                 rdata: 32'h0000_0000, serr: 1'b0, smi: 1'b0, sci: 1'b0};
    end
    else if (ce_i)
    begin
      st_ff <= nxt_st;
    end
  end

  // Message outputs come straight from flops
  assign serr_o = st_ff.serr;
  assign smi_o = st_ff.smi;
  assign sci_o = st_ff.sci;

endmodule

`default_nettype wire

// File: berl_assertions.sv
// Port checker for the error log block, bound to its top module
`timescale 1ns/10ps
`default_nettype none

module berl_assertions
  import berl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic pwr_rst_b_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [BERL_APB_AW-1:0] paddr_i,
  input wire logic [BERL_APB_DW-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [BERL_APB_DW-1:0] prdata_o,
  input wire logic bus_init_pin_b_i,
  input wire logic bus_data_parity_error_i,
  input wire logic data_strobe_glitch_i,
  input wire logic request_address_parity_error_i,
  input wire logic [BERL_LOG_W-1:0] hub_link_first_error_log_i,
  input wire logic [BERL_LOG_W-1:0] hub_link_next_error_log_i,
  input wire logic serr_o,
  input wire logic smi_o,
  input wire logic sci_o
);
  // ==========================================================================
  // Enable shadows, rebuilt from APB writes since the enables are internal
  // ==========================================================================
  logic [7:0] hl_en_ff, sci_en_ff, smi_en_ff, serr_en_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i or negedge pwr_rst_b_i)
  begin
    if (!rst_b_i || !pwr_rst_b_i)
    begin
      hl_en_ff <= 8'h00;
      sci_en_ff <= 8'h00;
      smi_en_ff <= 8'h00;
      serr_en_ff <= 8'h00;
    end
    else if (psel_i && penable_i && pwrite_i && ce_i && pstrb_i[0])
    begin
      if (paddr_i == BERL_ADR_HL_SERR_EN) hl_en_ff <= pwdata_i[7:0] & BERL_HL_EN_MASK;
      if (paddr_i == BERL_ADR_SB_SCI_EN) sci_en_ff <= pwdata_i[7:0];
      if (paddr_i == BERL_ADR_SB_SMI_EN) smi_en_ff <= pwdata_i[7:0];
      if (paddr_i == BERL_ADR_SB_SERR_EN) serr_en_ff <= pwdata_i[7:0];
    end
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i || !pwr_rst_b_i);
  AST_HL_SERR: assert property (
    |((hub_link_first_error_log_i | hub_link_next_error_log_i) & hl_en_ff) |=> serr_o)
    else $error("hub link flag with enable gave no serr");
  AST_SMI_OFF: assert property (smi_en_ff == 8'h00 |=> !smi_o)
    else $error("smi raised with no enable");
  AST_SCI_OFF: assert property (sci_en_ff == 8'h00 |=> !sci_o)
    else $error("sci raised with no enable");
  AST_EV_SERR: assert property (
    ce_i && bus_data_parity_error_i && serr_en_ff[BERL_SB_DATA_PAR] |-> ##2 serr_o)
    else $error("data parity error gave no serr");
  AST_EV_SMI: assert property (
    ce_i && request_address_parity_error_i && smi_en_ff[0] |-> ##2 smi_o)
    else $error("request parity error gave no smi");
  AST_EV_SCI: assert property (
    ce_i && data_strobe_glitch_i && sci_en_ff[1] |-> ##2 sci_o)
    else $error("data strobe glitch gave no sci");
  AST_PIN_SERR: assert property (
    $fell(bus_init_pin_b_i) && serr_en_ff[7] |-> ##[4:6] serr_o)
    else $error("bus init fall gave no serr");
  AST_HL_READ: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == BERL_ADR_HL_SERR_EN
    |-> prdata_o == {24'h0, hl_en_ff})
    else $error("hub enable read wrong");
  AST_SERR_EN_READ: assert property (
    psel_i && penable_i && !pwrite_i && paddr_i == BERL_ADR_SB_SERR_EN
    |-> prdata_o == {24'h0, serr_en_ff})
    else $error("serr enable read wrong");
endmodule

bind berl_top berl_assertions berl_assertions_i (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .pwr_rst_b_i(pwr_rst_b_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .bus_init_pin_b_i(bus_init_pin_b_i), .bus_data_parity_error_i(bus_data_parity_error_i),
  .data_strobe_glitch_i(data_strobe_glitch_i),
  .request_address_parity_error_i(request_address_parity_error_i),
  .hub_link_first_error_log_i(hub_link_first_error_log_i),
  .hub_link_next_error_log_i(hub_link_next_error_log_i),
  .serr_o(serr_o), .smi_o(smi_o), .sci_o(sci_o));

`default_nettype wire

// File: berl_bus_agent.sv
// Behavioural system bus agent that raises error pins and error strobes
`timescale 1ns/10ps
`default_nettype none

module berl_bus_agent
  import berl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic fire_i,
  input wire logic neg_i,
  input wire logic [7:0] mask_i,
  input wire logic [BERL_BUS_AW-1:0] tom_i,
  output logic bus_init_pin_b_o,
  output logic internal_error_pin_b_o,
  output logic machine_check_error_pin_b_o,
  output logic locked_io_cycle_o,
  output logic lock_maps_dram_o,
  output logic bus_addr_valid_o,
  output logic [BERL_BUS_AW-1:0] bus_addr_o,
  output logic bus_data_parity_error_o,
  output logic address_strobe_glitch_o,
  output logic data_strobe_glitch_o,
  output logic request_address_parity_error_o
);
  // ==========================================================================
  // Pins idle high through pull-ups; strobes last one cycle
  // ==========================================================================
  logic [2:0] low_cnt;
  initial
  begin
    {bus_init_pin_b_o, internal_error_pin_b_o, machine_check_error_pin_b_o} = 3'b111;
    {locked_io_cycle_o, lock_maps_dram_o, bus_addr_valid_o} = 3'b000;
    {bus_data_parity_error_o, address_strobe_glitch_o} = 2'b00;
    {data_strobe_glitch_o, request_address_parity_error_o} = 2'b00;
    bus_addr_o = '0;
    low_cnt = 3'd0;
  end
  // Pins stay low four cycles so the synchroniser surely sees the fall
  always @(posedge sys_clk_i)
  begin
    if (fire_i)
    begin
      bus_init_pin_b_o <= !mask_i[7];
      internal_error_pin_b_o <= !(mask_i[6] && tom_i[0]);
      machine_check_error_pin_b_o <= !(mask_i[6] && !tom_i[0]);
      low_cnt <= 3'd4;
    end
    else if (low_cnt != 3'd0)
    begin
      low_cnt <= low_cnt - 3'd1;
      if (low_cnt == 3'd1) {bus_init_pin_b_o, internal_error_pin_b_o} <= 2'b11;
      if (low_cnt == 3'd1) machine_check_error_pin_b_o <= 1'b1;
    end
    // Qualifiers and address wander while idle, so stale values prove nothing
    locked_io_cycle_o <= fire_i && mask_i[5];
    lock_maps_dram_o <= (fire_i && mask_i[5]) ? neg_i : !lock_maps_dram_o;
    bus_addr_valid_o <= fire_i && mask_i[4];
    bus_addr_o <= (fire_i && mask_i[4]) ? (neg_i ? tom_i : tom_i + 36'h1) : ~bus_addr_o;
    bus_data_parity_error_o <= fire_i && mask_i[3];
    address_strobe_glitch_o <= fire_i && mask_i[2];
    data_strobe_glitch_o <= fire_i && mask_i[1];
    request_address_parity_error_o <= fire_i && mask_i[0];
  end
endmodule

`default_nettype wire

// File: tb.sv
// Self-checking bench for the error log block against an integer model
`timescale 1ns/10ps
`default_nettype none

module tb;
  import berl_pkg::*;
  // ==========================================================================
  // Signals and model state
  // ==========================================================================
  logic clk = 1'b0, rst_b = 1'b0, pwr_rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, fire = 1'b0, neg = 1'b0, e, pready, pslverr, serr, smi, sci;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, d;
  logic [3:0] pstrb = 4'h1;
  logic [7:0] hf = 8'h00, hn = 8'h00, mask = 8'h00;
  logic [35:0] top_of_memory = 36'h1_0000_0000, ba;
  logic bi, ie, mc, lk, lm, av, dpe, asg, dsg, rpe;
  int mf = 0, mn = 0, hen = 0, sen = 0, men = 0, cen = 0, i, k;
  int fail_count = 0, num_checks = 0;
  logic [11:0] adrs [6] = '{BERL_ADR_HL_SERR_EN, BERL_ADR_SB_FIRST, BERL_ADR_SB_NEXT,
    BERL_ADR_SB_SCI_EN, BERL_ADR_SB_SMI_EN, BERL_ADR_SB_SERR_EN};

  berl_top berl_top_i (.sys_clk_i(clk), .rst_b_i(rst_b), .pwr_rst_b_i(pwr_rst_b),
    .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .bus_init_pin_b_i(bi), .internal_error_pin_b_i(ie),
    .machine_check_error_pin_b_i(mc), .locked_io_cycle_i(lk), .lock_maps_dram_i(lm),
    .bus_addr_valid_i(av), .bus_addr_i(ba), .top_of_memory_i(top_of_memory),
    .bus_data_parity_error_i(dpe), .address_strobe_glitch_i(asg),
    .data_strobe_glitch_i(dsg), .request_address_parity_error_i(rpe),
    .hub_link_first_error_log_i(hf), .hub_link_next_error_log_i(hn),
    .serr_o(serr), .smi_o(smi), .sci_o(sci));
  berl_bus_agent berl_bus_agent_i (.sys_clk_i(clk), .fire_i(fire), .neg_i(neg),
    .mask_i(mask), .tom_i(top_of_memory), .bus_init_pin_b_o(bi), .internal_error_pin_b_o(ie),
    .machine_check_error_pin_b_o(mc), .locked_io_cycle_o(lk), .lock_maps_dram_o(lm),
    .bus_addr_valid_o(av), .bus_addr_o(ba), .bus_data_parity_error_o(dpe),
    .address_strobe_glitch_o(asg), .data_strobe_glitch_o(dsg),
    .request_address_parity_error_o(rpe));

  always #5 clk = ~clk;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request holds until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    apb(1'b1, a, dat, r, e);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask
  task automatic msgchk;
    @(negedge clk);
    chk({29'h0, serr, smi, sci}, {29'h0, |((mf | mn) & sen) | |((hf | hn) & hen & 8'h51),
      |((mf | mn) & men), |((mf | mn) & cen)});
  endtask
  // Model: the first group lands in the first log, later ones in the next log
  task automatic fire_ev(input logic [7:0] m, input logic n);
    @(posedge clk);
    mask <= m;
    neg <= n;
    top_of_memory <= {4'h1, $urandom};
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (10) @(posedge clk);
    if (!n && mf == 0) mf = m;
    else if (!n) mn |= m;
  endtask
  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    void'($urandom(88));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    pwr_rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (adrs[i]) rchk(adrs[i], 32'h0);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000);
    wr(BERL_ADR_HL_SERR_EN, 32'hff);
    rchk(BERL_ADR_HL_SERR_EN, 32'h51);
    pstrb <= 4'h0;
    wr(BERL_ADR_HL_SERR_EN, 32'h0);
    pstrb <= 4'h1;
    rchk(BERL_ADR_HL_SERR_EN, 32'h51);
    for (k = 0; k < 8; k++)
    begin
      hen = $urandom % 256;
      wr(BERL_ADR_HL_SERR_EN, hen);
      hf <= 8'($urandom);
      hn <= 8'($urandom);
      repeat (3) @(posedge clk);
      msgchk;
    end
    hen = 0;
    wr(BERL_ADR_HL_SERR_EN, 32'h0);
    // Each flag gets at most one message type
    d = $urandom;
    sen = (d[7:0] & 8'h74) | 8'h88;
    men = (d[15:8] & 8'h74 & ~sen) | 8'h01;
    cen = (d[23:16] & 8'h74 & ~sen & ~men) | 8'h02;
    wr(BERL_ADR_SB_SERR_EN, sen);
    wr(BERL_ADR_SB_SMI_EN, men);
    wr(BERL_ADR_SB_SCI_EN, cen);
    rchk(BERL_ADR_SB_SERR_EN, sen);
    rchk(BERL_ADR_SB_SMI_EN, men);
    rchk(BERL_ADR_SB_SCI_EN, cen);
    // One cause at a time from a cleared log, then the ignored lookalikes
    for (i = 0; i <= 8; i++)
    begin
      wr(BERL_ADR_SB_FIRST, 32'hff);
      wr(BERL_ADR_SB_NEXT, 32'hff);
      mf = 0;
      mn = 0;
      fire_ev((i < 8) ? 8'h01 << i : 8'h30, i == 8);
      rchk(BERL_ADR_SB_FIRST, mf);
      msgchk;
    end
    for (k = 0; k < 16; k++)
    begin
      d = $urandom;
      fire_ev((|d[7:6]) ? d[7:0] & 8'hc0 : d[7:0] & 8'h3f, 1'b0);
      rchk(BERL_ADR_SB_FIRST, mf);
      rchk(BERL_ADR_SB_NEXT, mn);
      msgchk;
      if (k % 3 == 2)
      begin
        d = $urandom;
        wr(BERL_ADR_SB_FIRST, d[7:0]);
        wr(BERL_ADR_SB_NEXT, d[15:8]);
        mf &= ~d[7:0];
        mn &= ~d[15:8];
        rchk(BERL_ADR_SB_FIRST, mf);
        rchk(BERL_ADR_SB_NEXT, mn);
      end
    end
    // Warm reset keeps the logs but drops the enables
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    sen = 0;
    men = 0;
    cen = 0;
    rchk(BERL_ADR_SB_FIRST, mf);
    rchk(BERL_ADR_SB_NEXT, mn);
    rchk(BERL_ADR_SB_SERR_EN, 32'h0);
    msgchk;
    pwr_rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    pwr_rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    mf = 0;
    mn = 0;
    rchk(BERL_ADR_SB_FIRST, 32'h0);
    rchk(BERL_ADR_SB_NEXT, 32'h0);
    end_sim;
  end

  // Run needs under a thousand cycles; this limit of 20000 cycles leaves wide margin
  initial
  begin
    #200000;
    fail_count++;
    end_sim;
  end
endmodule

`default_nettype wire
